// File: hw/literal_move_multiply_exec.sv
// Executor for literal load, working-register store and literal multiply
`timescale 1ns/1ns
`include "lmm_consts.svh"
// Timing overview
// Each instruction spends four enabled clocks in the executor, one per
// quarter: decode and literal capture in the first, no action in the second,
// processing in the third and the result write in the fourth. The result
// becomes visible on the edge that returns the sequencer to the first
// quarter, so a new word may be offered back to back at that point.
// Operand and configuration inputs are sampled only at the decode edge,
// so they may change freely while an instruction is in flight.
// Unknown opcodes still consume four quarters but change nothing.
// No status flags exist in this block, so none can be disturbed.
// Holding the clock enable low freezes every register, including the
// quarter sequencer, without losing the instruction in flight.
// Valid pulses seen outside the first quarter are ignored.
module literal_move_multiply_exec (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic clk_en_in,
    // Instruction word, valid for one instruction cycle
    input wire logic [15:0] instr_in,
    input wire logic instr_valid_in,
    // Configuration
    input wire logic ext_set_en_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [11:0] index_base_in,
    // State shown to the core
    output logic [1:0] quarter_out,
    output logic [7:0] working_out,
    output logic [7:0] product_high_byte_out,
    output logic [7:0] product_low_byte_out,
    // Data memory write port
    output logic [11:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_we_out,
    output logic busy_out
);
    // Complete executor state: sequencer, captured word, results and
    // write port, registered together so every output is a flip-flop
    typedef struct packed {
        lmm_pkg::quarter_t q;
        lmm_pkg::op_t op;
        logic [7:0] lit;
        logic [11:0] addr;
        logic [7:0] w;
        logic [7:0] prod_h;
        logic [7:0] prod_l;
        logic [11:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_we;
        logic busy;
    } state_t;

    // Decode and address-forming nets
    state_t st_r;
    state_t st_nxt;
    logic [15:0] product;
    logic [7:0] f_field;
    logic acc_bit;
    logic [7:0] opc_byte;
    logic [6:0] opc_store;
    logic is_load;
    logic is_mul;
    logic is_store;
    logic take;
    logic idx_hit;
    logic hi_half;
    logic [11:0] banked_addr;
    logic [11:0] indexed_addr;
    logic [11:0] access_addr;
    logic [11:0] store_addr;

    // Instruction word fields
    assign f_field = instr_in[7:0];
    assign acc_bit = instr_in[`ACCESS_BIT];
    assign opc_byte = instr_in[15:8];
    assign opc_store = instr_in[15:9];

    // A word is taken only in the first quarter; later valids are ignored
    assign take = instr_valid_in && (st_r.q == lmm_pkg::Q1);

    // Opcode match, one flag per supported instruction
    always_comb begin
        is_load = 1'b0;
        is_mul = 1'b0;
        is_store = 1'b0;
        if (opc_byte == `OPC_LOAD_LIT_HI) begin
            is_load = 1'b1;
        end
        if (opc_byte == `OPC_MUL_LIT_HI) begin
            is_mul = 1'b1;
        end
        if (opc_store == `OPC_STORE_HI) begin
            is_store = 1'b1;
        end
    end

    // Candidate store addresses, one per addressing mode
    // The indexed sum wraps at twelve bits; software must keep it in range
    assign banked_addr = {bank_select_register_in, f_field};
    assign indexed_addr = index_base_in + {4'h0, f_field};
    assign hi_half = (f_field >= `ACCESS_SPLIT);
    assign access_addr = {hi_half ? `ACCESS_HI_BANK : 4'h0, f_field};
    assign idx_hit = ext_set_en_in && (f_field <= `IDX_LIMIT);

    // Bank choice for the store: bank select when the access bit is set,
    // otherwise indexed offset for low addresses in the extended set,
    // otherwise the access bank split between low and high halves
    always_comb begin
        store_addr = access_addr;
        if (acc_bit) begin
            store_addr = banked_addr;
        end else if (idx_hit) begin
            store_addr = indexed_addr;
        end
    end

    // Multiplier sees the captured literal and the working register
    lmm_multiplier u_mul (
        .a_in(st_r.w),
        .b_in(st_r.lit),
        .p_out(product)
    );

    // Quarter sequencing, decode capture and writeback
    // The sequencer waits in the first quarter until a word is offered,
    // then runs through the other three quarters without looking at the
    // instruction inputs again
    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_we = 1'b0;
        unique case (st_r.q)
            lmm_pkg::Q1: begin
                st_nxt.op = lmm_pkg::OP_NONE;
                st_nxt.busy = 1'b0;
                // Configuration inputs are sampled only here
                if (take) begin
                    st_nxt.q = lmm_pkg::Q2;
                    st_nxt.busy = 1'b1;
                    st_nxt.lit = f_field; // Literal read
                    if (is_load) begin
                        st_nxt.op = lmm_pkg::OP_LOAD_LIT;
                    end else if (is_mul) begin
                        st_nxt.op = lmm_pkg::OP_MUL_LIT;
                    end else if (is_store) begin
                        st_nxt.op = lmm_pkg::OP_STORE;
                        st_nxt.addr = store_addr;
                    end
                end
            end
            lmm_pkg::Q2: begin
                // Literal already captured at decode
                st_nxt.q = lmm_pkg::Q3;
            end
            lmm_pkg::Q3: begin
                // Product settles from registered operands
                st_nxt.q = lmm_pkg::Q4;
            end
            lmm_pkg::Q4: begin
                st_nxt.q = lmm_pkg::Q1;
                // Results land on the edge back to the first quarter
                unique case (st_r.op)
                    // Literal load writes only the working register
                    lmm_pkg::OP_LOAD_LIT: st_nxt.w = st_r.lit;
                    // Store pulses the write strobe for one enabled clock
                    lmm_pkg::OP_STORE: begin
                        st_nxt.mem_addr = st_r.addr;
                        st_nxt.mem_wdata = st_r.w;
                        st_nxt.mem_we = 1'b1;
                    end
                    lmm_pkg::OP_MUL_LIT: begin
                        // No flags exist here: no zero, carry or overflow report
                        st_nxt.prod_h = product[15:8];
                        st_nxt.prod_l = product[7:0];
                    end
                    lmm_pkg::OP_NONE: st_nxt.busy = 1'b0;
                endcase
            end
        endcase
    end

    // State register, frozen while enable is low
    // Reset clears the sequencer to the first quarter with no operation
    // pending, so no write strobe can follow reset release
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    // Sequencer position
    assign quarter_out = st_r.q;
    // Working register and product pair
    assign working_out = st_r.w;
    assign product_high_byte_out = st_r.prod_h;
    assign product_low_byte_out = st_r.prod_l;
    // Data memory write port
    assign mem_addr_out = st_r.mem_addr;
    assign mem_wdata_out = st_r.mem_wdata;
    assign mem_we_out = st_r.mem_we;
    // Instruction in flight; after a known opcode it stays set through the next first quarter
    assign busy_out = st_r.busy;
endmodule

// File: hw/lmm_consts.svh
// Opcodes, field positions and timing counts for the literal/move/multiply executor
`ifndef LMM_CONSTS_SVH
`define LMM_CONSTS_SVH
`define OPC_LOAD_LIT_HI 8'h0E
`define OPC_MUL_LIT_HI 8'h0D
`define OPC_STORE_HI 7'h37
`define ACCESS_BIT 8
`define IDX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HI_BANK 4'hF
`define QUARTERS 2'h3
`endif

// File: hw/lmm_pkg.sv
// Types for the literal/move/multiply executor
package lmm_pkg;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_LOAD_LIT,
        OP_STORE,
        OP_MUL_LIT
    } op_t;

    typedef enum logic [1:0] {
        Q1,
        Q2,
        Q3,
        Q4
    } quarter_t;
endpackage

// File: hw/lmm_multiplier.sv
// Unsigned 8x8 multiply stage for the executor
`timescale 1ns/1ns
module lmm_multiplier (
    // Operands
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    // Product
    output logic [15:0] p_out
);
    // Full-width unsigned product, no overflow possible
    assign p_out = 16'(a_in) * 16'(b_in);
endmodule

// File: tb/lmm_chk.sv
// Port assertions for the literal/move/multiply executor
`timescale 1ns/1ns
module lmm_chk (
    // Executor inputs
    input wire logic core_clk_in, nrst_in, clk_en_in, instr_valid_in, ext_set_en_in,
    input wire logic [15:0] instr_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [11:0] index_base_in,
    // Executor outputs
    input wire logic [1:0] quarter_out,
    input wire logic [7:0] working_out, mem_wdata_out,
    input wire logic [7:0] product_high_byte_out, product_low_byte_out,
    input wire logic [11:0] mem_addr_out,
    input wire logic mem_we_out, busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // Word taken in the first quarter, its opcode byte and file field
    wire logic take = clk_en_in && instr_valid_in && quarter_out == 2'h0;
    wire logic [7:0] h = instr_in[15:8];
    wire logic [7:0] f = instr_in[7:0];
    a_load_lands: assert property (take && h == 8'h0E ##1 clk_en_in[*3]
        |=> working_out == $past(f, 4)) else $error("bad load");
    a_product_pair: assert property (take && h == 8'h0D ##1 clk_en_in[*3]
        |=> {product_high_byte_out, product_low_byte_out} == $past(working_out) * $past(f, 4)
        && $stable(working_out)) else $error("bad product");
    a_bank_select: assert property (take && h == 8'h6F ##1 clk_en_in[*3]
        |=> mem_we_out && mem_addr_out == {$past(bank_select_register_in, 4), $past(f, 4)})
        else $error("bad banked address");
    a_access_bank: assert property (take && h == 8'h6E && !ext_set_en_in ##1 clk_en_in[*3]
        |=> mem_addr_out == {{4{$past(f, 4) >= 8'h60}}, $past(f, 4)}) else $error("bad access");
    a_indexed_offset: assert property (take && h == 8'h6E && ext_set_en_in && f <= 8'h5F
        ##1 clk_en_in[*3] |=> mem_addr_out == $past(index_base_in, 4) + $past(f, 4))
        else $error("bad indexed address");
    a_store_data: assert property (mem_we_out && $past(clk_en_in)
        |-> mem_wdata_out == $past(working_out) && $past(quarter_out) == 2'h3)
        else $error("bad store data");
    a_quarter_step: assert property (nrst_in
        |=> quarter_out == $past(quarter_out) + 2'($past(clk_en_in)
        && ($past(quarter_out) != 2'h0 || $past(instr_valid_in)))) else $error("bad quarter");
    a_busy_run: assert property (take |=> busy_out[*3]) else $error("busy dropped");
endmodule
bind literal_move_multiply_exec lmm_chk u_chk (.*);

// File: tb/tb_top.sv
// Random and corner stimulus for the literal/move/multiply executor
`timescale 1ns/1ns
module tb_top;
    logic core_clk_in = 0, nrst_in = 0, clk_en_in = 1, instr_valid_in = 0, ext_set_en_in = 0;
    logic [15:0] instr_in = 0;
    logic [3:0] bank_select_register_in = 0;
    logic [11:0] index_base_in = 0, mem_addr_out;
    logic [7:0] working_out, product_high_byte_out, product_low_byte_out, mem_wdata_out, w, k;
    logic [1:0] quarter_out, op;
    logic mem_we_out, busy_out, a;
    int mismatches = 0, total_checks = 0;
    literal_move_multiply_exec DUT (.*);
    // Clock
    always #4 core_clk_in = ~core_clk_in;
    task chk(input logic [23:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: %h %h", $time, s, e);
        end
    endtask
    task summarize;
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One word per four quarters; stray valids in later quarters must be ignored
    task run(input logic [15:0] i, input logic frz);
        instr_in = i;
        instr_valid_in = 1;
        @(negedge core_clk_in);
        instr_valid_in = $urandom;
        if (frz) begin
            clk_en_in = 0;
            repeat (2) @(negedge core_clk_in);
            chk(quarter_out, 1);
            clk_en_in = 1;
        end
        @(negedge core_clk_in);
        instr_valid_in = $urandom;
        @(negedge core_clk_in);
        instr_valid_in = 0;
        @(negedge core_clk_in);
    endtask
    // Expected store address
    function logic [11:0] ea(input logic [7:0] f);
        if (a) return {bank_select_register_in, f};
        if (ext_set_en_in && f <= 8'h5F) return index_base_in + f;
        return {f >= 8'h60 ? 4'hF : 4'h0, f};
    endfunction
    // Watchdog
    initial begin
        #20000;
        mismatches++;
        summarize;
    end
    // Main sequence
    initial begin
        void'($urandom(32'h2E70));
        repeat (5) @(negedge core_clk_in);
        nrst_in = 1;
        run(16'h0EE2, 0);
        run(16'h0DC4, 1);
        chk({product_high_byte_out, product_low_byte_out}, 16'hAD08);
        w = 8'hE2;
        repeat (150) begin
            op = $urandom;
            a = $urandom;
            k = $urandom % 2 ? 8'h5E + 8'($urandom % 4) : 8'($urandom);
            {ext_set_en_in, bank_select_register_in, index_base_in} = $urandom;
            run(op == 0 ? {8'h0E, k} : op == 1 ? {8'h0D, k} : op == 2 ? {7'h37, a, k} : {8'h00, k},
                $urandom % 4 == 0);
            if (op == 0) w = k;
            chk({quarter_out, busy_out}, {2'h0, op != 3});
            chk(working_out, w);
            chk(mem_we_out, op == 2);
            if (op == 1) chk({product_high_byte_out, product_low_byte_out}, w * k);
            if (op == 2) chk({mem_wdata_out, 4'h0, mem_addr_out}, {w, 4'h0, ea(k)});
        end
        nrst_in = 0;
        @(negedge core_clk_in);
        chk({working_out, product_high_byte_out, product_low_byte_out}, 0);
        nrst_in = 1;
        run(16'h0E5A, 0);
        chk(working_out, 8'h5A);
        summarize;
    end
endmodule
